// File: rtl/bridge_pkg.sv
// Shared constants and types of the serial link to APB bridge.
`default_nettype none
// Functional notes
// R1: Upper addresses go through bridge onto APB.
// R2: Bridged writes land after bridge delay, unaligned.
// R3: Pending bridge access rejects new ones with FAIL.
// R4: Idle bridge acknowledges every access with OK.
// R5: Timeout after eight cycles, extension field lengthens.
// R6: Timeout disable makes the period infinite.
// R7: Late and timeout interrupts only when unmasked.
// R8: Lower addresses served directly by link core.
// R9: Indirect read data fetched later from register.
// R10: Direct read returns APB data in response.
// R11: Available time is ten rows times half-columns.
// R12: Direct only if available exceeds processing time.
// R13: Control and APB run on master clock.
// R14: Manager uses indirect access for equalizer coefficients.
// R15: Other APB slaves insert no wait states.
// R16: Read-only status and last-read-address registers exist; here a status write clears the done, valid, late and timeout bits.
// R17: Indirect read starts APB, answers OK, zero.
// R18: Read finish sets valid, stores data, address.
// R19: Write answers OK at start, done later.
// R20: Indirect register read needs two read commands.
// R21: Pending clears on completion or timeout.
package bridge_pkg;

  typedef logic [15:0] addr_t;
  typedef logic [7:0]  data_t;
  typedef logic [3:0]  av_addr_t;

  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_CMD  = 2'b01,
    LK_RSP  = 2'b10
  } link_st_t;

  typedef enum logic [1:0] {
    AP_IDLE   = 2'b00,
    AP_SETUP  = 2'b01,
    AP_ACCESS = 2'b10
  } apb_st_t;

  // ==========================================================
  // Address map of the link core
  localparam addr_t BRIDGE_BASE  = 16'h1000;
  localparam addr_t ADDR_STAT    = 16'h0040;
  localparam addr_t ADDR_RDDATA  = 16'h0041;
  localparam addr_t ADDR_LAST_LO = 16'h0042;
  localparam addr_t ADDR_LAST_HI = 16'h0043;
  localparam addr_t ADDR_TOCTRL  = 16'h0044;
  localparam addr_t ADDR_MASK    = 16'h0045;

  // ==========================================================
  // Field positions and reset values
  localparam int ST_PEND   = 0;
  localparam int ST_DONE   = 1;
  localparam int ST_RDV    = 2;
  localparam int ST_LATE   = 3;
  localparam int ST_TOERR  = 4;
  localparam int TO_EXT_HI = 3;
  localparam int TO_DIRECT = 6;
  localparam int TO_DIS    = 7;
  localparam int MASK_LATE = 0;
  localparam int MASK_TO   = 1;
  localparam data_t TOCTRL_RST = 8'h00;
  localparam data_t MASK_RST   = 8'h03;

  // ==========================================================
  // Link framing and response codes
  localparam logic [5:0] CMD_LAST = 6'h19;
  localparam logic [5:0] DATA_IDX = 6'h02;
  localparam logic [5:0] RSP_END  = 6'h0a;
  localparam logic [5:0] RSP_LAST = 6'h09;
  localparam logic [3:0] RSP_MSB  = 4'h9;
  localparam logic [1:0] RSP_OK   = 2'h1;
  localparam logic [1:0] RSP_FAIL = 2'h2;

  // ==========================================================
  // Timing
  localparam logic [11:0] TIMEOUT_BASE  = 12'h008;
  localparam int          LINK_HALF_CYC = 8;
  localparam int          QTR_SCLK      = 19;
  localparam int          QTR_APB       = 17;

  // ==========================================================
  // Manager register map
  localparam av_addr_t AV_CMD     = 4'h0;
  localparam av_addr_t AV_STAT    = 4'h4;
  localparam int       CMD_WR_POS = 24;

endpackage
`default_nettype wire

// File: rtl/bridge_link_if.sv
// Serial link between the bridge manager and the bridged device.
`timescale 1ns/1ps
`default_nettype none
interface bridge_link_if;
  logic linkClk;
  logic cmdSd;
  logic rspSd;

  modport mgr (
    output linkClk,
    output cmdSd,
    input  rspSd
  );

  modport dev (
    input  linkClk,
    input  cmdSd,
    output rspSd
  );
endinterface // bridge_link_if
`default_nettype wire

// File: rtl/bridge_dev_end.sv
// Device end: link core registers and the APB bridge master.
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module bridge_dev_end (
  input  wire logic              mclk,    // Master clock.
  input  wire logic              rst_b,   // Async reset, active low.
  bridge_link_if.dev             link,    // Serial link.
  output var  bridge_pkg::addr_t paddr,   // APB address.
  output var  logic              psel,    // APB select.
  output var  logic              penable, // APB enable.
  output var  logic              pwrite,  // APB direction.
  output var  bridge_pkg::data_t pwdata,  // APB write data.
  input  wire bridge_pkg::data_t prdata,  // APB read data.
  input  wire logic              pready,  // APB ready.
  output var  logic              irq      // Interrupt, active high.
);
  import bridge_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [2:0]  sclkSy;
    logic [1:0]  sdSy;
    link_st_t    lst;
    logic [5:0]  bitCnt;
    logic [23:0] shReg;
    logic [1:0]  rspStat;
    data_t       rspData;
    logic        rspOut;
    logic        waitDirect;
    apb_st_t     ast;
    addr_t       paddr;
    logic        pwrite;
    data_t       pwdata;
    logic        psel;
    logic        penable;
    logic [11:0] toCnt;
    logic        pend;
    logic        done;
    logic        rdv;
    logic        late;
    logic        toErr;
    data_t       rdData;
    addr_t       lastAddr;
    data_t       toCtrl;
    data_t       irqMask;
    logic        irq;
  } dev_st_t;

  localparam dev_st_t DEV_RST = '{
    lst:     LK_IDLE,
    ast:     AP_IDLE,
    toCtrl:  TOCTRL_RST,
    irqMask: MASK_RST,
    default: '0
  };

  dev_st_t st_ff;
  dev_st_t nxt_st;

  logic        rise;
  logic        fall;
  logic        rxBit;
  logic        apbDone;
  logic        apbRdDone;
  logic [24:0] word;
  logic        cmdWr;
  addr_t       cmdAddr;
  data_t       cmdData;
  data_t       regVal;
  data_t       rspByte;
  logic [9:0]  rspVec;
  data_t       clr;
  logic        startApb;
  logic [11:0] limit;

  // Edges are taken from the second and third sampling stages.
  assign rise      = st_ff.sclkSy[1] & ~st_ff.sclkSy[2];
  assign fall      = ~st_ff.sclkSy[1] & st_ff.sclkSy[2];
  assign rxBit     = st_ff.sdSy[1];
  assign apbDone   = (st_ff.ast == AP_ACCESS) & pready;
  assign apbRdDone = apbDone & ~st_ff.pwrite;

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st   = st_ff;
    word     = {st_ff.shReg, rxBit};
    cmdWr    = word[24];
    cmdAddr  = word[23:8];
    cmdData  = word[7:0];
    clr      = 8'h00;
    startApb = 1'b0;
    limit    = TIMEOUT_BASE
             + {5'h00, st_ff.toCtrl[TO_EXT_HI:0], 3'h0}; // R5

    case (cmdAddr)
      ADDR_STAT:    regVal = {3'h0, st_ff.toErr, st_ff.late,
                              st_ff.rdv, st_ff.done,
                              st_ff.pend}; // R16
      ADDR_RDDATA:  regVal = st_ff.rdData; // R9
      ADDR_LAST_LO: regVal = st_ff.lastAddr[7:0]; // R16
      ADDR_LAST_HI: regVal = st_ff.lastAddr[15:8];
      ADDR_TOCTRL:  regVal = st_ff.toCtrl;
      ADDR_MASK:    regVal = st_ff.irqMask;
      default:      regVal = 8'h00;
    endcase

    // A direct read finishing at the data slot is still in time.
    rspByte = (st_ff.waitDirect && apbRdDone) ? prdata
                                               : st_ff.rspData;
    rspVec  = {st_ff.rspStat, rspByte};

    nxt_st.sclkSy = {st_ff.sclkSy[1:0], link.linkClk};
    nxt_st.sdSy   = {st_ff.sdSy[0], link.cmdSd};

    // --------------------------------------------------------
    // Link framing
    case (st_ff.lst)
      LK_IDLE: begin
        if (rise && rxBit) begin
          nxt_st.lst    = LK_CMD;
          nxt_st.bitCnt = 6'h01;
        end
      end
      LK_CMD: begin
        if (rise) begin
          nxt_st.shReg  = {st_ff.shReg[22:0], rxBit};
          nxt_st.bitCnt = st_ff.bitCnt + 6'h01;
          if (st_ff.bitCnt == CMD_LAST) begin
            nxt_st.lst     = LK_RSP;
            nxt_st.bitCnt  = 6'h00;
            nxt_st.rspStat = RSP_OK;
            nxt_st.rspData = 8'h00; // R17
            if (cmdAddr >= BRIDGE_BASE) begin // R1
              if (st_ff.pend) begin
                nxt_st.rspStat = RSP_FAIL; // R3
              end else begin
                startApb          = 1'b1; // R4
                nxt_st.waitDirect = ~cmdWr
                                  & st_ff.toCtrl[TO_DIRECT]; // R10
              end
            end else if (cmdWr) begin
              case (cmdAddr) // R8
                ADDR_STAT:   clr = cmdData;
                ADDR_TOCTRL: nxt_st.toCtrl = cmdData;
                ADDR_MASK:   nxt_st.irqMask = cmdData;
                default:     clr = 8'h00;
              endcase
            end else begin
              nxt_st.rspData = regVal; // R8
            end
          end
        end
      end
      LK_RSP: begin
        if (fall) begin
          nxt_st.bitCnt = st_ff.bitCnt + 6'h01;
          if (st_ff.bitCnt == RSP_END) begin
            nxt_st.rspOut = 1'b0;
            nxt_st.lst    = LK_IDLE;
          end else begin
            nxt_st.rspOut = rspVec[RSP_MSB - st_ff.bitCnt[3:0]];
          end
          if (st_ff.bitCnt == DATA_IDX) begin
            nxt_st.waitDirect = 1'b0;
            if (st_ff.waitDirect && !apbRdDone) begin
              nxt_st.late = 1'b1; // R10
            end
          end
        end
      end
      default: begin
        nxt_st.lst = LK_IDLE;
      end
    endcase

    // Software clears come first so that hardware sets win.
    nxt_st.done  = nxt_st.done & ~clr[ST_DONE];
    nxt_st.rdv   = nxt_st.rdv & ~clr[ST_RDV];
    nxt_st.late  = nxt_st.late & ~clr[ST_LATE];
    nxt_st.toErr = nxt_st.toErr & ~clr[ST_TOERR];

    // --------------------------------------------------------
    // APB master
    case (st_ff.ast)
      AP_IDLE: begin
        if (startApb) begin
          nxt_st.ast     = AP_SETUP; // R2
          nxt_st.psel    = 1'b1;
          nxt_st.penable = 1'b0;
          nxt_st.paddr   = cmdAddr;
          nxt_st.pwrite  = cmdWr;
          nxt_st.pwdata  = cmdData;
          nxt_st.pend    = 1'b1;
          nxt_st.done    = 1'b0;
          nxt_st.toCnt   = 12'h000;
        end
      end
      AP_SETUP: begin
        nxt_st.ast     = AP_ACCESS;
        nxt_st.penable = 1'b1;
        nxt_st.toCnt   = st_ff.toCnt + 12'h001;
      end
      AP_ACCESS: begin
        if (pready) begin
          // Zero-wait slaves finish on the first access cycle.
          nxt_st.ast        = AP_IDLE; // R15
          nxt_st.psel       = 1'b0;
          nxt_st.penable    = 1'b0;
          nxt_st.pend       = 1'b0; // R21
          nxt_st.done       = 1'b1; // R19
          nxt_st.waitDirect = 1'b0;
          if (!st_ff.pwrite) begin
            nxt_st.rdData   = prdata; // R18
            nxt_st.lastAddr = st_ff.paddr;
            nxt_st.rdv      = 1'b1;
            if (st_ff.waitDirect) begin
              nxt_st.rspData = prdata; // R10
            end
          end
        end else if (!st_ff.toCtrl[TO_DIS]
                     && (st_ff.toCnt + 12'h001) >= limit) begin // R6
          nxt_st.ast        = AP_IDLE; // R5
          nxt_st.psel       = 1'b0;
          nxt_st.penable    = 1'b0;
          nxt_st.pend       = 1'b0; // R21
          nxt_st.toErr      = 1'b1;
          nxt_st.waitDirect = 1'b0;
        end else begin
          nxt_st.toCnt = st_ff.toCnt + 12'h001;
        end
      end
      default: begin
        nxt_st.ast = AP_IDLE;
      end
    endcase

    nxt_st.irq = (nxt_st.late & ~nxt_st.irqMask[MASK_LATE])
               | (nxt_st.toErr & ~nxt_st.irqMask[MASK_TO]); // R7
  end

  // ==========================================================
  // Registers on the master clock
  always_ff @(posedge mclk or negedge rst_b) begin // R13
    if (!rst_b) begin
      st_ff <= DEV_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.rspSd = st_ff.rspOut;
  assign paddr      = st_ff.paddr;
  assign psel       = st_ff.psel;
  assign penable    = st_ff.penable;
  assign pwrite     = st_ff.pwrite;
  assign pwdata     = st_ff.pwdata;
  assign irq        = st_ff.irq;

endmodule // bridge_dev_end
`default_nettype wire

// File: rtl/bridge_mgr_end.sv
// Manager end: Avalon-MM command registers and link clock master.
`timescale 1ns/1ps
`default_nettype none
module bridge_mgr_end #(
  parameter int HALF_CYC  = bridge_pkg::LINK_HALF_CYC,
  parameter int COLS      = 2,
  parameter int APB_RATIO = 1,
  parameter int APB_WAIT  = 0
) (
  input  wire logic                 mclk,          // Master clock.
  input  wire logic                 rst_b,         // Async reset.
  bridge_link_if.mgr                link,          // Serial link.
  input  wire bridge_pkg::av_addr_t avAddress,     // Byte address.
  input  wire logic                 avRead,        // Read request.
  input  wire logic                 avWrite,       // Write request.
  input  wire logic [31:0]          avWriteData,   // Write data.
  output var  logic [31:0]          avReadData,    // Read data.
  output var  logic                 avWaitRequest  // Stall.
);
  import bridge_pkg::*;

  // Quarter-period units: ten rows of half the columns against
  // the processing time of the bridge.
  localparam logic DIRECT_OK = (COLS * 5 * 4)
    > (QTR_SCLK + QTR_APB * APB_RATIO + 4 * APB_WAIT * APB_RATIO); // R12

  typedef struct packed {
    logic [7:0]  divCnt;
    logic        lclk;
    link_st_t    lst;
    logic [5:0]  bitCnt;
    logic [24:0] txSh;
    logic [9:0]  rxSh;
    logic [1:0]  rspSy;
    logic        launch;
    logic        busy;
    logic [1:0]  lastStat;
    data_t       lastData;
    logic        waitReq;
    logic [31:0] rdData;
    logic        cmdOut;
  } mgr_st_t;

  localparam mgr_st_t MGR_RST = '{
    lst:     LK_IDLE,
    waitReq: 1'b1,
    default: '0
  };

  mgr_st_t     st_ff;
  mgr_st_t     nxt_st;
  logic        tick;
  logic        mfall;
  logic        mrise;
  logic [9:0]  rxNew;
  logic [31:0] status;

  assign tick   = st_ff.divCnt == 8'(HALF_CYC - 1);
  assign mfall  = tick & st_ff.lclk;
  assign mrise  = tick & ~st_ff.lclk;
  assign rxNew  = {st_ff.rxSh[8:0], st_ff.rspSy[1]};
  assign status = {16'h0000, st_ff.lastData, 4'h0, DIRECT_OK,
                   st_ff.lastStat, st_ff.busy}; // R11

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rspSy = {st_ff.rspSy[0], link.rspSd};
    if (tick) begin
      nxt_st.divCnt = 8'h00;
      nxt_st.lclk   = ~st_ff.lclk;
    end else begin
      nxt_st.divCnt = st_ff.divCnt + 8'h01;
    end

    case (st_ff.lst)
      LK_IDLE: begin
        if (mfall) begin
          nxt_st.cmdOut = st_ff.launch;
          if (st_ff.launch) begin
            nxt_st.lst    = LK_CMD;
            nxt_st.bitCnt = 6'h00;
            nxt_st.launch = 1'b0;
          end
        end
      end
      LK_CMD: begin
        if (mfall) begin
          nxt_st.cmdOut = st_ff.txSh[24];
          nxt_st.txSh   = {st_ff.txSh[23:0], 1'b0};
        end else if (mrise) begin
          nxt_st.bitCnt = st_ff.bitCnt + 6'h01;
          if (st_ff.bitCnt == CMD_LAST) begin
            nxt_st.lst    = LK_RSP;
            nxt_st.bitCnt = 6'h00;
          end
        end
      end
      LK_RSP: begin
        if (mfall) begin
          nxt_st.cmdOut = 1'b0;
        end else if (mrise) begin
          nxt_st.rxSh   = rxNew;
          nxt_st.bitCnt = st_ff.bitCnt + 6'h01;
          if (st_ff.bitCnt == RSP_LAST) begin
            nxt_st.lst      = LK_IDLE;
            nxt_st.busy     = 1'b0;
            nxt_st.lastStat = rxNew[9:8]; // R20
            nxt_st.lastData = rxNew[7:0]; // R9
          end
        end
      end
      default: begin
        nxt_st.lst = LK_IDLE;
      end
    endcase

    // Avalon slave: a command write stalls while a frame runs.
    if (st_ff.waitReq) begin
      if ((avRead || avWrite)
          && !(avWrite && avAddress == AV_CMD && st_ff.busy)) begin
        nxt_st.waitReq = 1'b0;
        nxt_st.rdData  = (avRead && avAddress == AV_STAT) ? status
                                                          : 32'h0;
      end
    end else begin
      nxt_st.waitReq = 1'b1;
      if (avWrite && avAddress == AV_CMD) begin
        nxt_st.busy   = 1'b1;
        nxt_st.launch = 1'b1;
        nxt_st.txSh   = {avWriteData[CMD_WR_POS], avWriteData[15:0],
                         avWriteData[23:16]};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= MGR_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.linkClk  = st_ff.lclk;
  assign link.cmdSd    = st_ff.cmdOut;
  assign avReadData    = st_ff.rdData;
  assign avWaitRequest = st_ff.waitReq;

endmodule // bridge_mgr_end
`default_nettype wire

// File: tb/bridge_link_assertions.sv
// Concurrent checks on the serial link and the APB side of the bridge.
`timescale 1ns/1ps
`default_nettype none
module bridge_link_assertions (
  input wire logic              mclk,    // Master clock.
  input wire logic              rst_b,   // Reset, active low.
  input wire logic              linkClk, // Link clock.
  input wire logic              cmdSd,   // Command bit.
  input wire logic              rspSd,   // Response bit.
  input wire bridge_pkg::addr_t paddr,   // APB address.
  input wire logic              psel,    // APB select.
  input wire logic              penable, // APB enable.
  input wire logic              pwrite,  // APB direction.
  input wire bridge_pkg::data_t pwdata,  // APB write data.
  input wire logic              pready   // APB ready.
);
  import bridge_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence sSetup;
    psel && !penable;
  endsequence
  sequence sAccess;
    psel && penable;
  endsequence
  a_link_half_period: assert property (
    $rose(linkClk) |-> linkClk [*8] ##1 !linkClk)
    else $error("Link clock half period wrong.");
  a_setup_access: assert property (
    $rose(psel) |-> sSetup ##1 sAccess)
    else $error("APB setup not followed by access.");
  a_upper_only: assert property (
    $rose(psel) |-> paddr >= BRIDGE_BASE)
    else $error("APB transfer for a core address.");
  a_complete_drop: assert property (
    psel && penable && pready |=> !psel && !penable)
    else $error("APB transfer not ended after ready.");
  a_hold_fields: assert property (
    sAccess |-> $stable(paddr) && $stable(pwrite) && $stable(pwdata))
    else $error("APB fields changed during transfer.");
  a_one_transfer: assert property (
    $fell(psel) |-> !psel [*8])
    else $error("APB transfers too close together.");
  a_rsp_on_low: assert property (
    $changed(rspSd) |-> !linkClk)
    else $error("Response bit changed while link clock high.");
  a_cmd_on_low: assert property (
    $changed(cmdSd) |-> !linkClk)
    else $error("Command bit changed while link clock high.");
endmodule // bridge_link_assertions
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench: manager and device ends joined over the link.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bridge_pkg::*;
  logic        mclk;
  logic        rst_b;
  av_addr_t    avAddress;
  logic        avRead;
  logic        avWrite;
  logic [31:0] avWriteData;
  logic [31:0] avReadData;
  logic        avWaitRequest;
  addr_t       paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  data_t       pwdata;
  data_t       prdata;
  logic        pready;
  logic        irq;
  logic        stall;
  data_t       mem [256];
  int          fails;
  int          checksDone;
  int          selCycles;
  logic [31:0] seed;
  logic [31:0] q;
  logic [1:0]  code;
  data_t       rd;
  addr_t       a;
  data_t       d;

  bridge_link_if link ();
  bridge_mgr_end u_bridge_mgr_end (.mclk(mclk), .rst_b(rst_b), .link(link),
    .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
    .avWriteData(avWriteData), .avReadData(avReadData),
    .avWaitRequest(avWaitRequest));
  bridge_dev_end u_bridge_dev_end (.mclk(mclk), .rst_b(rst_b), .link(link),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .irq(irq));
  bridge_link_assertions u_bridge_link_assertions (.mclk(mclk),
    .rst_b(rst_b), .linkClk(link.linkClk), .cmdSd(link.cmdSd),
    .rspSd(link.rspSd), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // APB slave with no wait states unless stalled by the bench.
  always @(posedge mclk) begin
    pready <= !stall;
    prdata <= mem[paddr[7:0]];
    if (psel && penable && pready && pwrite) begin
      mem[paddr[7:0]] <= pwdata;
    end
    if (psel) begin
      selCycles <= selCycles + 1;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Direct access test in quarter link periods.
  function automatic logic directOk(input int cols, input int ratio);
    return 20 * cols > QTR_SCLK + QTR_APB * ratio;
  endfunction

  task automatic results();
    $display("Checks %0d, mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] act, input logic [31:0] exp);
    checksDone++;
    if (act !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic avXfer(input logic wr, input av_addr_t ad,
                        input logic [31:0] wd, output logic [31:0] rv);
    int n;
    n = 0;
    avAddress   <= ad;
    avWrite     <= wr;
    avRead      <= !wr;
    avWriteData <= wd;
    do begin
      @(posedge mclk);
      n++;
    end while (avWaitRequest !== 1'b0 && n < 5000);
    if (avWaitRequest !== 1'b0) begin
      fails++;
      results();
    end
    rv = avReadData;
    avRead  <= 1'b0;
    avWrite <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic cmd(input logic wr, input addr_t ad, input data_t wd);
    logic [31:0] s;
    int          n;
    avXfer(1'b1, AV_CMD, {7'h00, wr, wd, ad}, s);
    n = 0;
    do begin
      avXfer(1'b0, AV_STAT, 32'h0, s);
      n++;
    end while (s[0] !== 1'b0 && n < 500);
    if (s[0] !== 1'b0) begin
      fails++;
      results();
    end
    code = s[2:1];
    rd   = s[15:8];
  endtask

  initial begin
    rst_b       = 1'b0;
    avAddress   = '0;
    avRead      = 1'b0;
    avWrite     = 1'b0;
    avWriteData = '0;
    prdata      = '0;
    pready      = 1'b0;
    stall       = 1'b0;
    fails       = 0;
    checksDone  = 0;
    selCycles   = 0;
    seed        = 32'he3fcc7f2;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    avXfer(1'b0, AV_STAT, 32'h0, q);
    check(q[3], directOk(2, 1));
    avXfer(1'b0, 4'h8, 32'h0, q);
    check(q, 32'h0);
    cmd(1'b0, ADDR_TOCTRL, 8'h00);
    check({code, rd}, {RSP_OK, TOCTRL_RST});
    cmd(1'b0, ADDR_MASK, 8'h00);
    check({code, rd}, {RSP_OK, MASK_RST});
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      a = (i == 0) ? BRIDGE_BASE : (i == 1) ? 16'hffff
        : (seed[15:0] | BRIDGE_BASE);
      d = seed[23:16];
      cmd(1'b1, a, d);
      check(code, RSP_OK);
      check(mem[a[7:0]], d);
      cmd(1'b0, ADDR_STAT, 8'h00);
      check(rd[ST_DONE:ST_PEND], 2'b10);
      cmd(1'b1, ADDR_STAT, 8'h06);
      cmd(1'b0, a, 8'h00);
      check({code, rd}, {RSP_OK, 8'h00});
      cmd(1'b0, ADDR_STAT, 8'h00);
      check(rd[ST_RDV], 1'b1);
      cmd(1'b0, ADDR_RDDATA, 8'h00);
      check(rd, d);
      cmd(1'b0, ADDR_LAST_LO, 8'h00);
      check(rd, a[7:0]);
      cmd(1'b0, ADDR_LAST_HI, 8'h00);
      check(rd, a[15:8]);
    end
    cmd(1'b1, ADDR_TOCTRL, 8'h40);
    cmd(1'b0, a, 8'h00);
    check({code, rd}, {RSP_OK, d});
    cmd(1'b1, ADDR_TOCTRL, 8'h80);
    stall <= 1'b1;
    cmd(1'b1, BRIDGE_BASE, 8'h5a);
    check(code, RSP_OK);
    cmd(1'b0, 16'h2000, 8'h00);
    check(code, RSP_FAIL);
    cmd(1'b0, ADDR_STAT, 8'h00);
    check(rd[ST_PEND], 1'b1);
    stall <= 1'b0;
    cmd(1'b0, ADDR_STAT, 8'h00);
    check(rd[ST_DONE:ST_PEND], 2'b10);
    check(mem[0], 8'h5a);
    // A direct read held up by wait states misses its data slot.
    cmd(1'b1, ADDR_TOCTRL, 8'hc0);
    stall <= 1'b1;
    cmd(1'b0, BRIDGE_BASE, 8'h00);
    check({code, rd}, {RSP_OK, 8'h00});
    stall <= 1'b0;
    cmd(1'b0, ADDR_STAT, 8'h00);
    check(rd[ST_LATE], 1'b1);
    cmd(1'b0, ADDR_RDDATA, 8'h00);
    check(rd, 8'h5a);
    for (int e = 0; e < 3; e++) begin
      cmd(1'b1, ADDR_TOCTRL, 8'(e));
      stall <= 1'b1;
      selCycles = 0;
      cmd(1'b1, BRIDGE_BASE, 8'h11);
      check(selCycles, 8 * (e + 1));
      stall <= 1'b0;
      cmd(1'b0, ADDR_STAT, 8'h00);
      check({rd[ST_TOERR], rd[ST_PEND]}, 2'b10);
      check(irq, 1'b0);
    end
    cmd(1'b1, ADDR_MASK, 8'h02);
    check(irq, 1'b1);
    cmd(1'b1, ADDR_STAT, 8'h08);
    check(irq, 1'b0);
    cmd(1'b1, ADDR_MASK, 8'h00);
    check(irq, 1'b1);
    cmd(1'b1, ADDR_STAT, 8'h1e);
    check(irq, 1'b0);
    results();
  end
endmodule // testbench
`default_nettype wire
